// ### bench/lpm_cpu_model.sv
// cpu core and peripheral stand-in: issues stop/wait pulses, holds wake levels
// assumes wake levels stay pending until the controller loads a vector or resets
`timescale 1ns/1ps
module lpm_cpu_model (
  input  wire logic          clk_i,
  input  wire logic          stop_i,
  input  wire logic          wait_i,
  input  wire logic [3:0]    raise_i,
  input  wire logic          vec_load_i,
  input  wire logic          sys_reset_i,
  output logic               stop_req_o,
  output logic               wait_req_o,
  output lpm_pkg::lpm_wake_t wake_o
);
  initial begin
    stop_req_o = 1'b0;
    wait_req_o = 1'b0;
    wake_o     = '0;
    forever begin
      @(posedge clk_i);
      stop_req_o <= stop_i;
      wait_req_o <= wait_i;
      // serviced sources drop, new ones latch
      if (vec_load_i === 1'b1 || sys_reset_i === 1'b1) begin
        wake_o <= '0;
      end else begin
        wake_o <= wake_o | raise_i;
      end
    end
  end
endmodule // lpm_cpu_model

// ### bench/tb_top.sv
// testbench for the low-power mode controller: stop/wait entry, wake, settle, slow divider
// assumes the cpu model above and a shortened settle count
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned SETTLE_N = 8;
  typedef struct packed { logic [15:0] vec; logic stack; } lpm_exp_t;
  logic               CLK_I, RESET_I, stop_c, wait_c, can_c, slow_set, slow_clr, imask_set, ext_set, ext_clr;
  logic [3:0]         raise;
  logic               stop_req, wait_req, IMASK_O, EXT_IRQ_EN_O, SLOW_MODE_SELECT_O, BUS_CLK_EN_O;
  logic               STACK_O, VEC_LOAD_O, SYS_RESET_O;
  logic [15:0]        VEC_ADDR_O;
  logic [3:0]         STATE_O;
  lpm_pkg::lpm_wake_t wake;
  lpm_pkg::lpm_ctl_t  CTL_O;
  lpm_exp_t           exp_q[$];
  lpm_exp_t           e;
  int                 mismatches, samples_checked, n;
  int unsigned        seed_v;

  lpm_cpu_model MODEL (.clk_i(CLK_I), .stop_i(stop_c), .wait_i(wait_c), .raise_i(raise),
    .vec_load_i(VEC_LOAD_O), .sys_reset_i(SYS_RESET_O), .stop_req_o(stop_req), .wait_req_o(wait_req),
    .wake_o(wake));
  lpm_ctrl #(.LONG_SETTLE(1'b1), .WDOG_IN_WAIT(1'b0), .SETTLE_LONG(SETTLE_N)) DUT (.CLK_I(CLK_I),
    .RESET_I(RESET_I), .STOP_REQ_I(stop_req), .WAIT_REQ_I(wait_req), .CAN_ASLEEP_I(can_c), .WAKE_I(wake),
    .SLOW_SET_I(slow_set), .SLOW_CLR_I(slow_clr), .IMASK_SET_I(imask_set), .EXT_IRQ_EN_SET_I(ext_set),
    .EXT_IRQ_EN_CLR_I(ext_clr), .IMASK_O(IMASK_O), .EXT_IRQ_EN_O(EXT_IRQ_EN_O),
    .SLOW_MODE_SELECT_O(SLOW_MODE_SELECT_O), .BUS_CLK_EN_O(BUS_CLK_EN_O), .CTL_O(CTL_O), .STACK_O(STACK_O),
    .VEC_LOAD_O(VEC_LOAD_O), .VEC_ADDR_O(VEC_ADDR_O), .SYS_RESET_O(SYS_RESET_O), .STATE_O(STATE_O));

  task automatic check(string nm, logic [15:0] x, logic [15:0] g);
    samples_checked++;
    if (x !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one cpu request, then the resulting state
  task automatic enter(logic stp, logic [3:0] st);
    @(posedge CLK_I);
    stop_c <= stp;
    wait_c <= ~stp;
    @(posedge CLK_I);
    stop_c <= 1'b0;
    wait_c <= 1'b0;
    repeat (3) @(posedge CLK_I);
    #1;
    check("state", {12'h000, st}, {12'h000, STATE_O});
  endtask

  // raise one wake source, plus random extra interrupts when it is not reset, and watch the way back to run
  task automatic wake_up(logic [3:0] src, int settle_exp);
    logic rst_seen;
    rst_seen = 1'b0;
    n = 0;
    repeat ($urandom_range(20, 1)) @(posedge CLK_I);
    exp_q.push_back('{src[0] ? lpm_pkg::VEC_RESET : lpm_pkg::VEC_IRQ, ~src[0]});
    raise <= src[0] ? src : (src | {3'($urandom_range(7, 0)), 1'b0});
    @(posedge CLK_I);
    raise <= 4'h0;
    repeat (60) begin
      @(posedge CLK_I);
      #1;
      if (STATE_O === 4'h4) n++;
      if (SYS_RESET_O === 1'b1) rst_seen = 1'b1;
    end
    check("settle cycles", settle_exp[15:0], n[15:0]);
    check("back in run", 16'h0001, {12'h000, STATE_O});
    check("system reset", {15'h0000, src[0]}, {15'h0000, rst_seen});
    check("ext enable", {15'h0000, ~src[0]}, {15'h0000, EXT_IRQ_EN_O});
  endtask

  // slow divider: enables seen in 32 cycles
  task automatic count_en(int x);
    repeat (3) @(posedge CLK_I);
    n = 0;
    repeat (32) begin
      @(posedge CLK_I);
      #1;
      if (BUS_CLK_EN_O === 1'b1) n++;
    end
    check("bus clock enables", x[15:0], n[15:0]);
  endtask

  always @(posedge CLK_I) begin
    if (VEC_LOAD_O === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected vector", 16'h0000, 16'h0001);
      end else begin
        e = exp_q.pop_front();
        check("vector", e.vec, VEC_ADDR_O);
        check("stacking", {15'h0000, e.stack}, {15'h0000, STACK_O});
      end
    end
  end

  initial begin
    CLK_I = 1'b0;
    forever #20 CLK_I = ~CLK_I;
  end

  initial begin
    repeat (20000) @(posedge CLK_I);
    mismatches++;
    finish_test();
  end

  initial begin
    {RESET_I, stop_c, wait_c, can_c, slow_set, slow_clr, imask_set, ext_set, ext_clr} = 9'h100;
    raise = 4'h0;
    seed_v = $urandom(1105);
    repeat (8) @(posedge CLK_I);
    RESET_I <= 1'b0;
    enter(1'b1, 4'h1);
    @(posedge CLK_I);
    slow_set <= 1'b1;
    @(posedge CLK_I);
    slow_set <= 1'b0;
    count_en(2);
    @(posedge CLK_I);
    slow_clr <= 1'b1;
    @(posedge CLK_I);
    slow_clr <= 1'b0;
    count_en(32);
    for (int m = 0; m < 2; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge CLK_I);
        {can_c, slow_set, ext_set, imask_set} <= 4'hF;
        @(posedge CLK_I);
        {slow_set, ext_set, imask_set} <= 3'h0;
        enter(m == 0, m == 0 ? 4'h2 : 4'h8);
        if (m == 0) begin
          check("stop controls", 16'h33F8, {2'h0, CTL_O.cpu_hold, CTL_O.wdog_clear, CTL_O.wdog_run, CTL_O.osc_en,
            CTL_O.periph_halt, CTL_O.io_freeze, CTL_O.pulse_length_freeze, CTL_O.eeprom_ro, CTL_O.adc_disable,
            CTL_O.timer_stop, CTL_O.sci_stop, BUS_CLK_EN_O, IMASK_O,
            SLOW_MODE_SELECT_O});
        end else begin
          check("wait controls", 16'h0109, {3'h0, CTL_O.eeprom_ro, CTL_O.wdog_clear, CTL_O.io_freeze,
            CTL_O.pulse_length_freeze, CTL_O.cpu_hold, CTL_O.timer_stop, CTL_O.adc_disable,
            CTL_O.sci_stop, CTL_O.periph_halt, CTL_O.osc_en, CTL_O.wdog_run, IMASK_O,
            EXT_IRQ_EN_O});
        end
        wake_up(4'h1 << k, m == 0 ? SETTLE_N : 0);
      end
    end
    // reset in mid-run from wait: state, controls, mask, enable and vector back to reset values
    @(posedge CLK_I);
    ext_set <= 1'b1;
    @(posedge CLK_I);
    ext_set <= 1'b0;
    enter(1'b0, 4'h8);
    @(posedge CLK_I);
    RESET_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 1'b0;
    @(posedge CLK_I);
    #1;
    check("reset state", 16'h0001, {12'h000, STATE_O});
    check("reset controls", 16'h0410, {5'h00, CTL_O});
    check("reset mask and enable", 16'h0002, {14'h0000, IMASK_O, EXT_IRQ_EN_O});
    check("reset vector", lpm_pkg::VEC_RESET, VEC_ADDR_O);
    check("vectors left", 16'h0000, 16'(exp_q.size()));
    finish_test();
  end
endmodule // tb_top

// ### design/lpm_ctrl.sv
// low-power mode controller: stop and wait sequencing, settle delay, slow divider
// assumes cpu requests are one-cycle pulses and wake sources are synchronous levels
//
// Notes on behaviour
// - stop gates oscillator, halts all internal processing
// - stop only takes effect while can asleep
// - entering stop clears interrupt mask bit
// - entering stop clears slow mode select
// - stop keeps registers, memory, io lines unchanged
// - can, port, external irq or reset end stop
// - wake vector: interrupt pair or reset pair
// - settle delay 16 or 4064 cycles by option
// - after settle, service interrupt or fetch reset
// - stacking for stop wake only at exit
// - stop clears watchdog, eeprom read-only, stops sci/timer/adc
// - pulse length outputs held during stop
// - wait suspends cpu only, peripherals keep running
// - watchdog in wait follows fixed option
// - eeprom program and charge pump continue in wait
// - entering wait clears mask, external enable untouched
// - any interrupt or reset ends wait
// - interrupt exit keeps state, reset exit resets all
// - stacking for wait wake only at exit
// - timer never disabled in wait
// - slow mode inserts divide-by-16 clock stage
`timescale 1ns/1ps

module lpm_ctrl #(
  parameter bit          LONG_SETTLE = 1'b1,
  parameter bit          WDOG_IN_WAIT = 1'b0,
  parameter int unsigned SETTLE_LONG = lpm_pkg::SETTLE_LONG_CY
) (
  input  wire logic             CLK_I,
  input  wire logic             RESET_I,
  input  wire logic             STOP_REQ_I,
  input  wire logic             WAIT_REQ_I,
  input  wire logic             CAN_ASLEEP_I,
  input  wire lpm_pkg::lpm_wake_t WAKE_I,
  input  wire logic             SLOW_SET_I,
  input  wire logic             SLOW_CLR_I,
  input  wire logic             IMASK_SET_I,
  input  wire logic             EXT_IRQ_EN_SET_I,
  input  wire logic             EXT_IRQ_EN_CLR_I,
  output logic                  IMASK_O,
  output logic                  EXT_IRQ_EN_O,
  output logic                  SLOW_MODE_SELECT_O,
  output logic                  BUS_CLK_EN_O,
  output lpm_pkg::lpm_ctl_t     CTL_O,
  output logic                  STACK_O,
  output logic                  VEC_LOAD_O,
  output logic [15:0]           VEC_ADDR_O,
  output logic                  SYS_RESET_O,
  output logic [3:0]            STATE_O
);

  localparam int unsigned SETTLE_N = LONG_SETTLE ? SETTLE_LONG : lpm_pkg::SETTLE_SHORT_CY;
  localparam logic [lpm_pkg::CNT_W-1:0] SETTLE_LAST = lpm_pkg::CNT_W'(SETTLE_N - 1);
  localparam logic [3:0] DIV_LAST = 4'(lpm_pkg::SLOW_DIV - 1);

  lpm_pkg::lpm_state_t         state_r;
  lpm_pkg::lpm_state_t         state_nxt;
  logic [lpm_pkg::CNT_W-1:0]   cnt_r;
  logic [3:0]                  div_r;
  logic                        wake_irq_r;
  logic                        imask_r;
  logic                        ext_en_r;
  logic                        sm_r;
  logic                        clk_en_r;
  logic                        stack_r;
  logic                        vload_r;
  logic [15:0]                 vec_r;
  logic                        sysrst_r;
  lpm_pkg::lpm_ctl_t           ctl_r;
  lpm_pkg::lpm_ctl_t           ctl_nxt;

  wire any_irq     = WAKE_I.can_irq | WAKE_I.port_irq | WAKE_I.ext_irq;
  wire any_wake    = any_irq | WAKE_I.reset_req;
  wire stop_ok     = STOP_REQ_I & CAN_ASLEEP_I;
  wire in_run      = (state_r == lpm_pkg::LPM_RUN);
  wire enter_stop  = in_run & stop_ok;
  wire enter_wait  = in_run & WAIT_REQ_I & ~stop_ok;
  wire stop_wake   = (state_r == lpm_pkg::LPM_STOP) & any_wake;
  wire settle_done = (state_r == lpm_pkg::LPM_SETTLE) & (cnt_r == SETTLE_LAST);
  wire wait_wake   = (state_r == lpm_pkg::LPM_WAIT) & any_wake;
  wire leave_lp    = settle_done | wait_wake;
  wire rst_exit    = leave_lp & (settle_done ? ~wake_irq_r : WAKE_I.reset_req);
  wire div_tick    = ~sm_r | (div_r == DIV_LAST);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lpm_pkg::LPM_RUN: begin
        if (enter_stop) begin
          state_nxt = lpm_pkg::LPM_STOP;
        end else if (enter_wait) begin
          state_nxt = lpm_pkg::LPM_WAIT;
        end
      end
      lpm_pkg::LPM_STOP: begin
        if (stop_wake) begin
          state_nxt = lpm_pkg::LPM_SETTLE;
        end
      end
      lpm_pkg::LPM_SETTLE: begin
        if (settle_done) begin
          state_nxt = lpm_pkg::LPM_RUN;
        end
      end
      lpm_pkg::LPM_WAIT: begin
        if (wait_wake) begin
          state_nxt = lpm_pkg::LPM_RUN;
        end
      end
    endcase
  end

  // peripheral controls per state
  always_comb begin
    ctl_nxt = '0;
    ctl_nxt.osc_en   = 1'b1;
    ctl_nxt.wdog_run = 1'b1;
    unique case (state_nxt)
      lpm_pkg::LPM_RUN: begin
      end
      lpm_pkg::LPM_STOP: begin
        ctl_nxt.osc_en              = 1'b0;
        ctl_nxt.cpu_hold            = 1'b1;
        ctl_nxt.periph_halt         = 1'b1;
        ctl_nxt.io_freeze           = 1'b1;
        ctl_nxt.pulse_length_freeze = 1'b1;
        ctl_nxt.wdog_clear          = 1'b1;
        ctl_nxt.wdog_run            = 1'b0;
        ctl_nxt.eeprom_ro           = 1'b1;
        ctl_nxt.adc_disable         = 1'b1;
        ctl_nxt.timer_stop          = 1'b1;
        ctl_nxt.sci_stop            = 1'b1;
      end
      lpm_pkg::LPM_SETTLE: begin
        ctl_nxt.cpu_hold            = 1'b1;
        ctl_nxt.periph_halt         = 1'b1;
        ctl_nxt.io_freeze           = 1'b1;
        ctl_nxt.pulse_length_freeze = 1'b1;
        ctl_nxt.wdog_clear          = 1'b1;
        ctl_nxt.wdog_run            = 1'b0;
        ctl_nxt.eeprom_ro           = 1'b1;
        ctl_nxt.adc_disable         = 1'b1;
        ctl_nxt.timer_stop          = 1'b1;
        ctl_nxt.sci_stop            = 1'b1;
      end
      lpm_pkg::LPM_WAIT: begin
        ctl_nxt.cpu_hold = 1'b1;
        ctl_nxt.wdog_run = WDOG_IN_WAIT;
        // timer, sci, adc, eeprom pump, can stay enabled
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state_r <= lpm_pkg::LPM_RUN;
      ctl_r   <= '{osc_en: 1'b1, wdog_run: 1'b1, default: 1'b0};
    end else begin
      state_r <= state_nxt;
      ctl_r   <= ctl_nxt;
    end
  end

  // settle counter runs only with oscillator back on
  always_ff @(posedge CLK_I) begin
    if (RESET_I || state_r != lpm_pkg::LPM_SETTLE) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // remember cause of stop wake; reset wins over interrupt
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      wake_irq_r <= 1'b0;
    end else if (stop_wake) begin
      wake_irq_r <= ~WAKE_I.reset_req;
    end
  end

  // mask bit: hardware clear wins over software set
  always_ff @(posedge CLK_I) begin
    if (RESET_I || rst_exit) begin
      imask_r <= 1'b1;
    end else if (enter_stop || enter_wait) begin
      imask_r <= 1'b0;
    end else if (IMASK_SET_I) begin
      imask_r <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I || rst_exit) begin
      ext_en_r <= 1'b0;
    end else if (EXT_IRQ_EN_SET_I) begin
      ext_en_r <= 1'b1;
    end else if (EXT_IRQ_EN_CLR_I) begin
      ext_en_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I || rst_exit) begin
      sm_r <= lpm_pkg::SM_RESET;
    end else if (enter_stop) begin
      sm_r <= 1'b0;
    end else if (SLOW_SET_I && in_run) begin
      sm_r <= 1'b1;
    end else if (SLOW_CLR_I) begin
      sm_r <= 1'b0;
    end
  end

  // divide-by-16 bus clock enable
  always_ff @(posedge CLK_I) begin
    if (RESET_I || !sm_r || div_tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      clk_en_r <= 1'b0;
    end else begin
      clk_en_r <= div_tick & (state_nxt != lpm_pkg::LPM_STOP) & (state_nxt != lpm_pkg::LPM_SETTLE);
    end
  end

  // exit actions: stack and vector only at leaving
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      stack_r  <= 1'b0;
      vload_r  <= 1'b0;
      vec_r    <= lpm_pkg::VEC_RESET;
      sysrst_r <= 1'b0;
    end else begin
      stack_r  <= leave_lp & ~rst_exit;
      vload_r  <= leave_lp;
      vec_r    <= !leave_lp ? vec_r : rst_exit ? lpm_pkg::VEC_RESET : lpm_pkg::VEC_IRQ;
      sysrst_r <= rst_exit;
    end
  end

  assign IMASK_O            = imask_r;
  assign EXT_IRQ_EN_O       = ext_en_r;
  assign SLOW_MODE_SELECT_O = sm_r;
  assign BUS_CLK_EN_O       = clk_en_r;
  assign CTL_O              = ctl_r;
  assign STACK_O            = stack_r;
  assign VEC_LOAD_O         = vload_r;
  assign VEC_ADDR_O         = vec_r;
  assign SYS_RESET_O        = sysrst_r;
  assign STATE_O            = state_r;

  AST_STOP_NEEDS_CAN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (in_run && STOP_REQ_I && !CAN_ASLEEP_I) |=> (state_r != lpm_pkg::LPM_STOP))
    else $error("stop entered while can awake");
  AST_OSC_OFF: assert property (@(posedge CLK_I) disable iff (RESET_I)
    enter_stop |=> !CTL_O.osc_en && CTL_O.periph_halt)
    else $error("oscillator not gated in stop");
  AST_MASK_CLR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (enter_stop || enter_wait) |=> !IMASK_O)
    else $error("mask not cleared on entry");
  AST_SM_CLR: assert property (@(posedge CLK_I) disable iff (RESET_I)
    enter_stop |=> !SLOW_MODE_SELECT_O)
    else $error("slow mode not cleared in stop");
  AST_SETTLE_LEN: assert property (@(posedge CLK_I) disable iff (RESET_I)
    $rose(state_r == lpm_pkg::LPM_SETTLE) |-> (cnt_r == '0))
    else $error("settle counter not restarted");
  AST_NO_EARLY_STACK: assert property (@(posedge CLK_I) disable iff (RESET_I)
    STACK_O |-> $past(leave_lp))
    else $error("stacking before exit");
  AST_WAIT_PERIPH: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state_r == lpm_pkg::LPM_WAIT) |-> !CTL_O.timer_stop && CTL_O.osc_en && CTL_O.cpu_hold)
    else $error("timer stopped in wait");
  AST_WAIT_EXIT: assert property (@(posedge CLK_I) disable iff (RESET_I)
    wait_wake |=> VEC_LOAD_O && (state_r == lpm_pkg::LPM_RUN))
    else $error("wait not left on wake");
  AST_RESET_VEC: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (VEC_LOAD_O && SYS_RESET_O) |-> (VEC_ADDR_O == lpm_pkg::VEC_RESET))
    else $error("reset wake wrong vector");
  AST_PLM_HOLD: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (state_r == lpm_pkg::LPM_STOP) |-> CTL_O.pulse_length_freeze && CTL_O.io_freeze)
    else $error("outputs not frozen in stop");

  COV_STOP_IRQ: cover property (@(posedge CLK_I) disable iff (RESET_I)
    stop_wake && !WAKE_I.reset_req);
  COV_STOP_RST: cover property (@(posedge CLK_I) disable iff (RESET_I)
    settle_done && rst_exit);
  COV_WAIT_IRQ: cover property (@(posedge CLK_I) disable iff (RESET_I)
    wait_wake && !WAKE_I.reset_req);

endmodule // lpm_ctrl

// ### include/lpm_pkg.sv
// package for the low-power mode controller: constants, states, port groups
// assumes a cpu core that pulses stop/wait requests and honours the hold and vector outputs
package lpm_pkg;

  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned SETTLE_SHORT_CY = 16;
  localparam int unsigned SETTLE_LONG_CY  = 4064;
  localparam int unsigned SLOW_DIV        = 16;
  localparam int unsigned CNT_W           = 12;
  localparam logic [15:0] VEC_IRQ         = 16'h3FFA;
  localparam logic [15:0] VEC_RESET       = 16'h3FFE;
  localparam logic        SM_RESET        = 1'b0;

  typedef enum logic [3:0] {
    LPM_RUN    = 4'b0001,
    LPM_STOP   = 4'b0010,
    LPM_SETTLE = 4'b0100,
    LPM_WAIT   = 4'b1000
  } lpm_state_t;

  // wake sources
  typedef struct packed {
    logic can_irq;
    logic port_irq;
    logic ext_irq;
    logic reset_req;
  } lpm_wake_t;

  // peripheral controls driven during low-power modes
  typedef struct packed {
    logic osc_en;
    logic cpu_hold;
    logic periph_halt;
    logic io_freeze;
    logic pulse_length_freeze;
    logic wdog_clear;
    logic wdog_run;
    logic eeprom_ro;
    logic adc_disable;
    logic timer_stop;
    logic sci_stop;
  } lpm_ctl_t;

endpackage : lpm_pkg
